// ### pchr_defines.svh
// Offsets, field positions and fixed values of the configuration header registers
`ifndef PCHR_DEFINES_SVH
`define PCHR_DEFINES_SVH

`define PCHR_DW_CMDSTS    6'h01
`define PCHR_DW_CIS       6'h0a
`define PCHR_DW_SUBSYS    6'h0b
`define PCHR_DW_CAPHEAD   6'h0d
`define PCHR_DW_INTR      6'h0f
`define PCHR_DW_CAP_PM    6'h37
`define PCHR_DW_CAP_PCIX  6'h39
`define PCHR_DW_CAP_MSI   6'h3c

`define PCHR_CIS_ON       32'h00000022
`define PCHR_CIS_OFF      32'h00000000
`define PCHR_CIS_SPACE    3'h2
`define PCHR_CIS_OFFSET   29'h00000004

`define PCHR_CAP_HEAD     8'hdc
`define PCHR_NEXT_PM      8'he4
`define PCHR_NEXT_PCIX    8'hf0
`define PCHR_NEXT_END     8'h00
`define PCHR_ID_PM        8'h01
`define PCHR_ID_PCIX      8'h07
`define PCHR_ID_MSI       8'h05

`define PCHR_MAX_LAT      8'h00
`define PCHR_MIN_GNT      8'hff
`define PCHR_INT_PIN_A    8'h01
`define PCHR_INT_PIN_B    8'h02
`define PCHR_INT_LINE_RST 8'h00
`define PCHR_CMD_RST      11'h000

`define PCHR_CMD_MASTER   2
`define PCHR_CMD_INTDIS   10
`define PCHR_STS_DEVSEL   2'h1
`define PCHR_NUM_ERR      6

`endif

// ### pchr_pkg.sv
// Types of the configuration header register block
package pchr_pkg;

	typedef struct packed {
		logic [10:0] cmd;
		logic [7:0]  int_line;
		logic [15:0] ssid;
		logic [15:0] ssvid;
		logic        cis_en;
		logic        msi_off;
		logic [7:0]  int_pin;
		logic [31:0] rdata;
		logic        ack;
		logic        int_out;
		logic        split_ok;
	} pchr_state_t;

	typedef struct packed {
		logic flag;
	} pchr_flag_state_t;

endpackage : pchr_pkg

// ### pchr_w1c_flag.sv
// One sticky error flag, cleared by writing one
`timescale 1ns/100ps
module pchr_w1c_flag
	import pchr_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic set_evt,
	input  wire logic clr_req,
	output logic      flag_r
);

	pchr_flag_state_t st_r;
	pchr_flag_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Set beats clear so a same-cycle event is kept
		if (set_evt) begin
			st_nxt.flag = 1'b1; // [RULE18]
		end else if (clr_req) begin
			st_nxt.flag = 1'b0; // [RULE19]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag_r = st_r.flag;

	chk_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
		set_evt |=> flag_r) // [RULE19]
		else $error("flag lost an event");

endmodule : pchr_w1c_flag

// ### pchr_cfg_regs.sv
// Configuration header registers: pointer, subsystem ids, capability chain, command and status
`timescale 1ns/100ps
`include "pchr_defines.svh"

//Contract
//RULE1: Pointer 22h only with both EEPROM bits set
//RULE2: Space field 0 config, 1-6 BARs, 7 ROM
//RULE3: Offset field holds 4, 32 bytes in
//RULE4: Subsystem ids from EEPROM, else built-in defaults
//RULE5: Capability list head reads DCh
//RULE6: Chain DCh to E4h to F0h to 00h
//RULE7: Conventional mode, MSI off: PCI-X next zero
//RULE8: Max latency 00h, min grant FFh
//RULE9: Interrupt pin 1 or 2 from EEPROM
//RULE10: Single function enabled: interrupt pin reads 1
//RULE11: Software writes interrupt line; device stores it
//RULE12: Command bits 9:0 reset to zero
//RULE13: PCI-X mode may split-complete without mastering
//RULE14: Status bit 3 pending; interrupt disable gates
//RULE15: Status bit 4 reads one
//RULE16: 66 MHz one, user features zero, timing 01b
//RULE17: Fast back-to-back capable reads zero
//RULE18: Six error flags, reset to zero
//RULE19: Error flags clear on writing one
//RULE20: Reserved command and status bits read zero
module pchr_cfg_regs
	import pchr_pkg::*;
#(
	parameter bit          HAS_INT_DIS    = 1'b1,
	parameter logic [15:0] DFLT_SSID      = 16'h0a5a,
	parameter logic [15:0] DFLT_SSVID     = 16'h1234
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [5:0]  cfg_dw_idx,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata_r,
	output logic             cfg_ack_r,
	input  wire logic        ee_load,
	input  wire logic        ee_valid,
	input  wire logic        ee_clkrun_en,
	input  wire logic        ee_bar32,
	input  wire logic        ee_msi_dis,
	input  wire logic        ee_int_pin_b,
	input  wire logic        dual_func_en,
	input  wire logic [15:0] ee_ssid,
	input  wire logic [15:0] ee_ssvid,
	input  wire logic        pcix_mode,
	input  wire logic        int_pending,
	input  wire logic [5:0]  err_evt,
	output logic      [10:0] cmd_r,
	output logic             int_assert_r,
	output logic             split_ok_r
);

	pchr_state_t                st_r;
	pchr_state_t                st_nxt;
	logic [`PCHR_NUM_ERR-1:0]   err_flag;
	logic [`PCHR_NUM_ERR-1:0]   err_clr;
	logic [15:0]                sts_word;
	logic [31:0]                rd_word;
	logic [7:0]                 pcix_next;
	logic                       wr_cs;

	// Error flags: bit 8, then bits 11 to 15
	assign wr_cs = cfg_wr && (cfg_dw_idx == `PCHR_DW_CMDSTS);
	assign err_clr[0] = wr_cs && cfg_be[3] && cfg_wdata[24]; // [RULE19]
	genvar gi;
	generate
		for (gi = 1; gi < `PCHR_NUM_ERR; gi++) begin : g_err_clr
			assign err_clr[gi] = wr_cs && cfg_be[3] && cfg_wdata[26+gi]; // [RULE19]
		end
		for (gi = 0; gi < `PCHR_NUM_ERR; gi++) begin : g_err
			pchr_w1c_flag u_flag (
				.clk_sys (clk_sys),
				.rst_b   (rst_b),
				.set_evt (err_evt[gi]),
				.clr_req (err_clr[gi]),
				.flag_r  (err_flag[gi])
			);
		end
	endgenerate

	// Status word as read
	always_comb begin
		sts_word        = 16'h0000; // [RULE20]
		sts_word[3]     = HAS_INT_DIS ? int_pending : 1'b0; // [RULE14]
		sts_word[4]     = 1'b1; // [RULE15]
		sts_word[5]     = 1'b1; // [RULE16]
		sts_word[6]     = 1'b0; // [RULE16]
		// No fast back-to-back support, so zero in either mode
		sts_word[7]     = 1'b0; // [RULE17]
		sts_word[8]     = err_flag[0]; // [RULE18]
		sts_word[10:9]  = `PCHR_STS_DEVSEL; // [RULE16]
		sts_word[15:11] = err_flag[5:1]; // [RULE18]
	end

	// MSI capability leaves the chain only in conventional mode
	assign pcix_next = (st_r.msi_off && !pcix_mode) ? `PCHR_NEXT_END : `PCHR_NEXT_PCIX; // [RULE6] [RULE7]

	// Read decode; unmapped dwords read zero
	always_comb begin
		rd_word = 32'h00000000;
		unique case (cfg_dw_idx)
			`PCHR_DW_CMDSTS: begin
				rd_word = {sts_word, 5'h00, st_r.cmd}; // [RULE20]
			end
			`PCHR_DW_CIS: begin
				rd_word = st_r.cis_en ? {`PCHR_CIS_OFFSET, `PCHR_CIS_SPACE} : `PCHR_CIS_OFF; // [RULE1] [RULE2] [RULE3]
			end
			`PCHR_DW_SUBSYS: begin
				rd_word = {st_r.ssid, st_r.ssvid}; // [RULE4]
			end
			`PCHR_DW_CAPHEAD: begin
				rd_word = {24'h000000, `PCHR_CAP_HEAD}; // [RULE5]
			end
			`PCHR_DW_INTR: begin
				rd_word = {`PCHR_MAX_LAT, `PCHR_MIN_GNT, st_r.int_pin, st_r.int_line}; // [RULE8] [RULE11]
			end
			`PCHR_DW_CAP_PM: begin
				rd_word = {16'h0000, `PCHR_NEXT_PM, `PCHR_ID_PM}; // [RULE6]
			end
			`PCHR_DW_CAP_PCIX: begin
				rd_word = {16'h0000, pcix_next, `PCHR_ID_PCIX}; // [RULE6]
			end
			`PCHR_DW_CAP_MSI: begin
				if (!(st_r.msi_off && !pcix_mode)) begin
					rd_word = {16'h0000, `PCHR_NEXT_END, `PCHR_ID_MSI}; // [RULE6]
				end
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		st_nxt       = st_r;
		st_nxt.ack   = cfg_rd || cfg_wr;
		st_nxt.rdata = cfg_rd ? rd_word : 32'h00000000;
		// EEPROM words are latched once per load so reads stay stable
		if (ee_load) begin
			st_nxt.ssid    = ee_valid ? ee_ssid : DFLT_SSID; // [RULE4]
			st_nxt.ssvid   = ee_valid ? ee_ssvid : DFLT_SSVID; // [RULE4]
			st_nxt.cis_en  = ee_valid && ee_clkrun_en && ee_bar32; // [RULE1]
			st_nxt.msi_off = ee_valid && ee_msi_dis; // [RULE7]
			if (dual_func_en && ee_valid && ee_int_pin_b) begin
				st_nxt.int_pin = `PCHR_INT_PIN_B; // [RULE9]
			end else begin
				st_nxt.int_pin = `PCHR_INT_PIN_A; // [RULE9] [RULE10]
			end
		end
		if (wr_cs && cfg_be[0]) begin
			st_nxt.cmd[7:0] = cfg_wdata[7:0]; // [RULE12]
		end
		if (wr_cs && cfg_be[1]) begin
			st_nxt.cmd[9:8] = cfg_wdata[9:8]; // [RULE12]
			st_nxt.cmd[10]  = HAS_INT_DIS ? cfg_wdata[10] : 1'b0; // [RULE20]
		end
		if (cfg_wr && (cfg_dw_idx == `PCHR_DW_INTR) && cfg_be[0]) begin
			st_nxt.int_line = cfg_wdata[7:0]; // [RULE11]
		end
		st_nxt.int_out  = int_pending && !(HAS_INT_DIS && st_r.cmd[`PCHR_CMD_INTDIS]); // [RULE14]
		// Split completions must drain even with mastering off
		st_nxt.split_ok = st_r.cmd[`PCHR_CMD_MASTER] || pcix_mode; // [RULE13]
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_r          <= '0;
			st_r.cmd      <= `PCHR_CMD_RST; // [RULE12]
			st_r.int_line <= `PCHR_INT_LINE_RST;
			st_r.ssid     <= DFLT_SSID; // [RULE4]
			st_r.ssvid    <= DFLT_SSVID; // [RULE4]
			st_r.int_pin  <= `PCHR_INT_PIN_A; // [RULE10]
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cfg_rdata_r  = st_r.rdata;
	assign cfg_ack_r    = st_r.ack;
	assign cmd_r        = st_r.cmd;
	assign int_assert_r = st_r.int_out;
	assign split_ok_r   = st_r.split_ok;

	// Checks
	sequence s_rd_cis;
		cfg_rd && (cfg_dw_idx == `PCHR_DW_CIS);
	endsequence

	sequence s_rd_intr;
		cfg_rd && (cfg_dw_idx == `PCHR_DW_INTR);
	endsequence

	sequence s_rd_cmdsts;
		cfg_rd && (cfg_dw_idx == `PCHR_DW_CMDSTS);
	endsequence

	chk_cis_value: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE1]
		s_rd_cis |=> (cfg_rdata_r == ($past(st_r.cis_en) ? `PCHR_CIS_ON : `PCHR_CIS_OFF)))
		else $error("pointer value wrong");

	chk_cis_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE3]
		s_rd_cis ##0 st_r.cis_en |=> (cfg_rdata_r[31:3] == 29'h4))
		else $error("pointer offset not four");

	chk_subsys_dflt: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE4]
		(ee_load && !ee_valid) |=> (st_r.ssid == DFLT_SSID) && (st_r.ssvid == DFLT_SSVID))
		else $error("subsystem defaults not used");

	chk_cap_head: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE5]
		cfg_rd && (cfg_dw_idx == `PCHR_DW_CAPHEAD) |=> (cfg_rdata_r[7:0] == 8'hdc))
		else $error("capability head wrong");

	chk_msi_drop: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE7]
		cfg_rd && (cfg_dw_idx == `PCHR_DW_CAP_PCIX) && st_r.msi_off && !pcix_mode
		|=> (cfg_rdata_r[15:8] == 8'h00))
		else $error("chain not cut");

	chk_lat_gnt: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE8]
		s_rd_intr |=> (cfg_rdata_r[31:16] == 16'h00ff))
		else $error("latency or grant wrong");

	chk_single_pin: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE10]
		(ee_load && !dual_func_en) |=> (st_r.int_pin == 8'h01))
		else $error("single function pin not one");

	chk_cmd_reset: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE12]
		$rose(rst_b) |-> (cmd_r == 11'h000))
		else $error("command not reset");

	chk_split_ok: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE13]
		pcix_mode ##1 pcix_mode |-> split_ok_r)
		else $error("split completion blocked");

	chk_int_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE14]
		(int_pending && !cmd_r[10]) |=> int_assert_r)
		else $error("interrupt not driven");

	chk_int_mask: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE14]
		(HAS_INT_DIS && cmd_r[10]) |=> !int_assert_r)
		else $error("interrupt not gated");

	chk_sts_fixed: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE16]
		s_rd_cmdsts |=> (cfg_rdata_r[26:25] == 2'h1) && (cfg_rdata_r[23:20] == 4'h3)
		&& (cfg_rdata_r[18:16] == 3'h0) && (cfg_rdata_r[15:11] == 5'h00))
		else $error("status fixed bits wrong");

	chk_err_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE19]
		(wr_cs && cfg_be[3] && cfg_wdata[31] && !err_evt[5]) |=> !err_flag[5])
		else $error("parity flag not cleared");

	chk_err_keep: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE18]
		err_flag[2] && !err_clr[2] |=> err_flag[2])
		else $error("error flag dropped");

endmodule : pchr_cfg_regs

// ### pchr_host_model.sv
// Configuration master model issuing single dword reads and writes
`timescale 1ns/100ps
module pchr_host_model (
	input  wire logic        clk_sys,
	input  wire logic [31:0] cfg_rdata_r,
	input  wire logic        cfg_ack_r,
	output logic             cfg_rd,
	output logic             cfg_wr,
	output logic      [5:0]  cfg_dw_idx,
	output logic      [3:0]  cfg_be,
	output logic      [31:0] cfg_wdata
);
	initial begin
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_dw_idx = 6'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h00000000;
	end

	// One-cycle request, then wait a bounded time for the answer
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd,
			output logic [31:0] rd, output logic ok);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		cfg_rd = !w;
		cfg_wr = w;
		cfg_dw_idx = idx;
		cfg_be = be;
		cfg_wdata = wd;
		@(posedge clk_sys);
		#1;
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		// Released lines inverted so stale values cannot pass for held ones
		cfg_dw_idx = ~idx;
		cfg_be = ~be;
		cfg_wdata = ~wd;
		while (cfg_ack_r !== 1'b1 && n < 4) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		ok = (cfg_ack_r === 1'b1);
		rd = cfg_rdata_r;
	endtask : xfer
endmodule : pchr_host_model

// ### testbench.sv
// Self-checking bench for the configuration header registers
`timescale 1ns/100ps
module testbench;
	localparam logic [15:0] DSID = 16'h0a5a;
	localparam logic [15:0] DSVID = 16'h1234;
	localparam int          TMO = 20000;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        ee_load, ee_valid, ee_clkrun_en, ee_bar32, ee_msi_dis, ee_int_pin_b;
	logic        dual_func_en, pcix_mode, int_pending;
	logic [15:0] ee_ssid, ee_ssvid;
	logic [5:0]  err_evt;
	wire         cfg_rd, cfg_wr, cfg_ack_r, int_assert_r, split_ok_r;
	wire  [5:0]  cfg_dw_idx;
	wire  [3:0]  cfg_be;
	wire  [31:0] cfg_wdata, cfg_rdata_r;
	wire  [10:0] cmd_r;
	logic [10:0] cmd_m;
	logic [7:0]  line_m;
	logic [15:0] flg_m, sid, svid;
	logic        v, ck, b32, md, pb, df;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cycles = 0;

	pchr_cfg_regs #(.HAS_INT_DIS(1'b1), .DFLT_SSID(DSID), .DFLT_SSVID(DSVID)) i_dut (
		.clk_sys, .rst_b, .cfg_rd, .cfg_wr, .cfg_dw_idx, .cfg_be, .cfg_wdata, .cfg_rdata_r, .cfg_ack_r,
		.ee_load, .ee_valid, .ee_clkrun_en, .ee_bar32, .ee_msi_dis, .ee_int_pin_b, .dual_func_en,
		.ee_ssid, .ee_ssvid, .pcix_mode, .int_pending, .err_evt, .cmd_r, .int_assert_r, .split_ok_r);
	pchr_host_model i_host (.clk_sys, .cfg_rdata_r, .cfg_ack_r, .cfg_rd, .cfg_wr, .cfg_dw_idx, .cfg_be, .cfg_wdata);

	always #2 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == TMO) begin
			miscompares++;
			final_report;
		end
	end

	function automatic logic [31:0] exp_dw(input logic [5:0] idx);
		logic off;
		logic [7:0] pin;
		off = v & md & ~pcix_mode;
		pin = (df & v & pb) ? 8'h02 : 8'h01;
		case (idx)
			6'h01: return {16'h0230 | flg_m | {12'h000, int_pending, 3'h0}, 5'h00, cmd_m};
			6'h0a: return (v & ck & b32) ? 32'h00000022 : 32'h00000000;
			6'h0b: return v ? {sid, svid} : {DSID, DSVID};
			6'h0d: return 32'h000000dc;
			6'h0f: return {8'h00, 8'hff, pin, line_m};
			6'h37: return 32'h0000e401;
			6'h39: return {16'h0000, off ? 8'h00 : 8'hf0, 8'h07};
			6'h3c: return off ? 32'h00000000 : 32'h00000005;
			default: return 32'h00000000;
		endcase
	endfunction : exp_dw

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic chk(input logic [5:0] idx, input logic [31:0] msk);
		logic [31:0] d;
		logic ok;
		i_host.xfer(1'b0, idx, 4'h0, $urandom, d, ok);
		cmp({31'h0, ok}, 32'h00000001);
		cmp(d & msk, exp_dw(idx) & msk);
	endtask : chk

	task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
		logic [31:0] d;
		logic ok;
		i_host.xfer(1'b1, idx, be, wd, d, ok);
		cmp({31'h0, ok}, 32'h00000001);
		cmp(d, 32'h00000000);
		if (idx == 6'h01 && be[0]) cmd_m[7:0] = wd[7:0];
		if (idx == 6'h01 && be[1]) cmd_m[10:8] = wd[10:8];
		if (idx == 6'h01 && be[3]) flg_m[15:8] = flg_m[15:8] & ~wd[31:24];
		if (idx == 6'h0f && be[0]) line_m = wd[7:0];
	endtask : wr

	task automatic check_all;
		chk(6'h01, 32'hffffffff);
		chk(6'h0a, 32'hffffffff);
		chk(6'h0b, 32'hffffffff);
		chk(6'h0d, 32'h000000ff);
		chk(6'h0f, 32'hffffffff);
		chk(6'h37, 32'h0000ffff);
		chk(6'h39, 32'h0000ffff);
		chk(6'h3c, 32'h0000ffff);
		chk(6'h3f, 32'hffffffff);
	endtask : check_all

	// Ee inputs other than ee_valid are inverted after the load to show they were sampled
	task automatic load;
		@(posedge clk_sys);
		#1;
		{ee_valid, ee_clkrun_en, ee_bar32, ee_msi_dis, ee_int_pin_b, dual_func_en} = 6'($urandom);
		{ee_ssid, ee_ssvid} = $urandom;
		{v, ck, b32, md, pb, df, sid, svid} = {ee_valid, ee_clkrun_en, ee_bar32, ee_msi_dis, ee_int_pin_b,
			dual_func_en, ee_ssid, ee_ssvid};
		ee_load = 1'b1;
		@(posedge clk_sys);
		#1;
		ee_load = 1'b0;
		{ee_clkrun_en, ee_bar32, ee_msi_dis, ee_int_pin_b, ee_ssid, ee_ssvid} =
			~{ee_clkrun_en, ee_bar32, ee_msi_dis, ee_int_pin_b, ee_ssid, ee_ssvid};
	endtask : load

	task automatic evt(input logic [5:0] e);
		@(posedge clk_sys);
		#1;
		err_evt = e;
		flg_m = flg_m | {e[5:1], 2'b00, e[0], 8'h00};
		@(posedge clk_sys);
		#1;
		err_evt = 6'h00;
	endtask : evt

	task automatic reset_dut;
		rst_b = 1'b0;
		pcix_mode = 1'b0;
		{cmd_m, line_m, flg_m, v, ck, b32, md, pb, df} = '0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
	endtask : reset_dut

	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		{ee_load, ee_valid, ee_clkrun_en, ee_bar32, ee_msi_dis, ee_int_pin_b, dual_func_en} = '0;
		{pcix_mode, int_pending, ee_ssid, ee_ssvid, err_evt} = '0;
		void'($urandom(32'h3d10));
		reset_dut;
		check_all;
		$display("test reset values done");
		repeat (12) begin
			load;
			int_pending = 1'($urandom);
			wr(6'h01, 4'($urandom), $urandom);
			wr(6'h0f, 4'($urandom), $urandom);
			wr(6'($urandom), 4'hf, $urandom);
			evt(6'($urandom));
			check_all;
			cmp({31'h0, int_assert_r}, {31'h0, int_pending & ~cmd_m[10]});
			cmp({31'h0, split_ok_r}, {31'h0, cmd_m[2]});
			cmp({21'h0, cmd_r}, {21'h0, cmd_m});
		end
		$display("test random traffic done");
		evt(6'h3f);
		wr(6'h01, 4'h8, 32'h00ff0000);
		chk(6'h01, 32'hffffffff);
		wr(6'h01, 4'h8, 32'hff000000);
		chk(6'h01, 32'hffffffff);
		pcix_mode = 1'b1;
		wr(6'h01, 4'h3, 32'h00000000);
		chk(6'h01, 32'hffffffff);
		cmp({31'h0, split_ok_r}, 32'h00000001);
		check_all;
		$display("test flags and mode done");
		reset_dut;
		check_all;
		$display("test second reset done");
		final_report;
	end
endmodule : testbench
